// ===== hvc_defs.svh
/*
  Command codes, field positions, reset values and timing counts for the
  high-voltage configuration-one register block.
  Assumes a 125 MHz system clock (8 ns period).
*/
`ifndef HVC_DEFS_SVH
`define HVC_DEFS_SVH

// Command codes in the command register (bits 3-0)
`define HVC_CMD_RD_CFG1        4'h1
`define HVC_CMD_RD_MON         4'h3
`define HVC_CMD_WR_CFG1        4'h9

// Field positions in the configuration register
`define HVC_BIT_ATTEN          7
`define HVC_BIT_TEMP_MON       6
`define HVC_BIT_VCHAN_SHORT    5
`define HVC_BIT_WAKE_SENSE     4
`define HVC_BIT_IO_REENABLE    3
`define HVC_BIT_LIN_PASSIVE    2

// Field position of the wake level in the monitor register
`define HVC_MON_BIT_WAKE       7

// Reset values
`define HVC_CFG1_RESET         8'h00
`define HVC_DATA_RESET         8'h00
`define HVC_CMD_RESET          4'h0

// Timing
`define HVC_CLK_PERIOD_NS      8
`define HVC_LIN_SHORT_NS       20000
`define HVC_WAKE_SHORT_NS      400000
`define HVC_LIN_SHORT_CYCLES   ((`HVC_LIN_SHORT_NS + `HVC_CLK_PERIOD_NS - 1) / `HVC_CLK_PERIOD_NS)
`define HVC_WAKE_SHORT_CYCLES  ((`HVC_WAKE_SHORT_NS + `HVC_CLK_PERIOD_NS - 1) / `HVC_CLK_PERIOD_NS)

`endif

// ===== hvc_pkg.sv
/*
  Types for the high-voltage configuration-one register block.
  Assumes hvc_defs.svh supplies the numeric constants.
*/
package hvc_pkg;

  // Decoded configuration controls driven to the analog section
  typedef struct packed {
    logic atten_en;
    logic temp_mon_en;
    logic vchan_short;
    logic wake_sense_en;
    logic io_reenable;
    logic lin_passive;
    logic [1:0] spare;
  } hvc_cfg1_t;

  // Protection state per high-voltage pin
  typedef struct packed {
    logic pin_en;
    logic short_flag;
  } hvc_prot_t;

endpackage

// ===== hvc_config1.sv
/*
  High-voltage configuration-one register with its command/data access path,
  short-circuit protection timers for the LIN and wake pins, wake-pin edge
  sensing and the monitor read-back of the wake level.
  Assumes pin-level inputs are asynchronous and the processor side drives
  the command and data strobes synchronously to sys_clk_i.
*/
// Functional notes
// R01: The configuration register is 8 read/write bits that reset to 0x00.
// R02: It is off the memory map and reached only through the command and data registers.
// R03: Bit 7 powers the voltage attenuator and its buffer.
// R04: Bit 6 enables the high-voltage temperature monitor feeding the temperature converter.
// R05: Bit 5 shorts the voltage-channel input at the attenuator for a noise test.
// R06: Bit 4 enables wake-pin sensing and each wake edge then raises an interrupt.
// R07: With sensing on, the live wake level reads in bit 7 of the monitor register.
// R08: A short over 20 us on LIN (active mode) or 400 us on wake disables that pin, and bit 3 set re-enables it.
// R09: Software writes one to bit 3 to restart the wake driver after a thermal shutdown.
// R10: Writing one to bit 3 clears pending short flags and re-enables disabled pins.
// R11: Bit 2 set selects passive LIN protection, clear selects active.
// R12: Passive mode flags and interrupts on a LIN short but keeps the pin enabled.
// R13: Active mode flags, interrupts and disables the LIN pin until bit 3 is written with one.
// R14: Short durations are counted on the system clock and restart when the overcurrent goes away.
`include "hvc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module hvc_config1
  import hvc_pkg::*;
#(
  parameter int CNT_W              = 16,
  parameter int LIN_SHORT_CYCLES   = `HVC_LIN_SHORT_CYCLES,
  parameter int WAKE_SHORT_CYCLES  = `HVC_WAKE_SHORT_CYCLES
) (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       cmd_wr_i,
  input  wire logic [3:0] cmd_code_i,
  input  wire logic       data_wr_i,
  input  wire logic [7:0] data_wdata_i,
  input  wire logic       wake_io_pin_i,
  input  wire logic       lin_overcurrent_i,
  input  wire logic       wake_overcurrent_i,
  input  wire logic       wake_thermal_i,
  output logic      [7:0] data_rdata_o,
  output logic      [3:0] cmd_rdata_o,
  output logic            atten_en_o,
  output logic            temp_mon_en_o,
  output logic            vchan_short_o,
  output logic            wake_sense_en_o,
  output logic            lin_passive_o,
  output logic            lin_pin_en_o,
  output logic            wake_pin_en_o,
  output logic            lin_short_flag_o,
  output logic            wake_short_flag_o,
  output logic            hv_irq_o
);

  // Register state
  logic [7:0]  hv_config_one_reg;
  logic [7:0]  high_voltage_data_reg;
  logic [3:0]  high_voltage_command_reg;
  logic [7:0]  hv_config_one_next;
  logic [7:0]  high_voltage_data_next;

  // Pin synchronisers: index 0 LIN overcurrent, 1 wake overcurrent, 2 thermal, 3 wake level
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic        wake_prev_reg;

  // Protection state: index 0 LIN, 1 wake
  hvc_prot_t   prot_reg [2];
  logic [CNT_W-1:0] short_cnt_reg [2];
  logic [CNT_W-1:0] thr_w [2];
  logic [1:0]  short_det_w;
  logic [1:0]  disable_w;
  logic        irq_reg;

  // Decode of command and data strobes
  hvc_cfg1_t   cfg_w;
  wire         cmd_wr_cfg_w   = cmd_wr_i && (cmd_code_i == `HVC_CMD_WR_CFG1);
  wire         cmd_rd_cfg_w   = cmd_wr_i && (cmd_code_i == `HVC_CMD_RD_CFG1);
  wire         cmd_rd_mon_w   = cmd_wr_i && (cmd_code_i == `HVC_CMD_RD_MON);
  wire         reenable_w     = cmd_wr_cfg_w && high_voltage_data_reg[`HVC_BIT_IO_REENABLE];
  wire         thermal_sync_w = sync2_reg[2];
  wire         wake_level_w   = sync2_reg[3];
  wire         wake_edge_w    = cfg_w.wake_sense_en && (wake_level_w ^ wake_prev_reg);
  wire [7:0]   monitor_w      = {cfg_w.wake_sense_en & wake_level_w, 7'h00};

  assign cfg_w = hvc_cfg1_t'(hv_config_one_reg);
  assign thr_w[0] = CNT_W'(LIN_SHORT_CYCLES);
  assign thr_w[1] = CNT_W'(WAKE_SHORT_CYCLES);

  // Configuration write through the data register
  assign hv_config_one_next = cmd_wr_cfg_w ? high_voltage_data_reg : hv_config_one_reg; // [R01] [R02]

  // Data register: processor write, or read-back command loads it
  assign high_voltage_data_next =
    data_wr_i    ? data_wdata_i      :
    cmd_rd_cfg_w ? hv_config_one_reg :                                 // [R02]
    cmd_rd_mon_w ? monitor_w         :                                 // [R07]
                   high_voltage_data_reg;

  // Disable decisions: LIN only in active mode, wake always; thermal hits wake
  assign disable_w[0] = short_det_w[0] && !cfg_w.lin_passive;          // [R11] [R12] [R13]
  assign disable_w[1] = short_det_w[1] || thermal_sync_w;              // [R08] [R09]

  // Configuration register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hv_config_one_reg <= `HVC_CFG1_RESET;                            // [R01]
    end else begin
      hv_config_one_reg <= hv_config_one_next;
    end
  end

  // Data register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      high_voltage_data_reg <= `HVC_DATA_RESET;
    end else begin
      high_voltage_data_reg <= high_voltage_data_next;
    end
  end

  // Command register keeps the last code written, known or not
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      high_voltage_command_reg <= `HVC_CMD_RESET;
    end else if (cmd_wr_i) begin
      high_voltage_command_reg <= cmd_code_i;
    end
  end

  // Two-stage synchronisers for the asynchronous pin inputs
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {wake_io_pin_i, wake_thermal_i, wake_overcurrent_i, lin_overcurrent_i};
      sync2_reg <= sync1_reg;
    end
  end

  // Wake edge history; clears to the idle-low level so sensing starts quiet
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wake_prev_reg <= 1'b0;
    end else begin
      wake_prev_reg <= wake_level_w;
    end
  end

  // Per-pin short timer and protection state
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_pin
      wire             oc_w          = sync2_reg[g];
      wire             restart_w     = !oc_w || !prot_reg[g].pin_en;
      wire             counting_w    = short_cnt_reg[g] <= thr_w[g];
      wire [CNT_W-1:0] cnt_next_w;
      wire             pin_en_next_w;
      wire             flag_next_w;

      assign short_det_w[g] = oc_w && prot_reg[g].pin_en
                              && (short_cnt_reg[g] == thr_w[g]);       // [R08]

      // Count stops one past the threshold, so one short gives one detection
      assign cnt_next_w = restart_w  ? '0                           :  // [R14]
                          counting_w ? short_cnt_reg[g] + CNT_W'(1) :  // [R14]
                                       short_cnt_reg[g];

      // A disable or a new short wins over a re-enable in the same cycle
      assign pin_en_next_w = disable_w[g]   ? 1'b0 :                   // [R13]
                             reenable_w     ? 1'b1 :                   // [R10]
                                              prot_reg[g].pin_en;
      assign flag_next_w   = short_det_w[g] ? 1'b1 :                   // [R12] [R13]
                             reenable_w     ? 1'b0 :                   // [R10]
                                              prot_reg[g].short_flag;

      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          short_cnt_reg[g] <= '0;
        end else begin
          short_cnt_reg[g] <= cnt_next_w;
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          prot_reg[g] <= '{pin_en: 1'b1, short_flag: 1'b0};
        end else begin
          prot_reg[g] <= '{pin_en: pin_en_next_w, short_flag: flag_next_w};
        end
      end
    end
  endgenerate

  // Interrupt pulse on any detected short or sensed wake edge
  wire         irq_next_w     = (|short_det_w) || wake_edge_w;         // [R06] [R12] [R13]

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next_w;
    end
  end

  assign data_rdata_o      = high_voltage_data_reg;
  assign cmd_rdata_o       = high_voltage_command_reg;
  assign atten_en_o        = cfg_w.atten_en;                           // [R03]
  assign temp_mon_en_o     = cfg_w.temp_mon_en;                        // [R04]
  assign vchan_short_o     = cfg_w.vchan_short;                        // [R05]
  assign wake_sense_en_o   = cfg_w.wake_sense_en;                      // [R06]
  assign lin_passive_o     = cfg_w.lin_passive;                        // [R11]
  assign lin_pin_en_o      = prot_reg[0].pin_en;
  assign wake_pin_en_o     = prot_reg[1].pin_en;
  assign lin_short_flag_o  = prot_reg[0].short_flag;
  assign wake_short_flag_o = prot_reg[1].short_flag;
  assign hv_irq_o          = irq_reg;

endmodule

`default_nettype wire

// ===== hvc_config1_chk.sv
/* Concurrent checks on the ports of hvc_config1.
   Assumes a bind into every hvc_config1; it reads only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module hvc_chk #(
  parameter int LIN_SHORT_CYCLES = 2500
) (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       cmd_wr_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic       data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic       lin_overcurrent_i,
  input wire logic [7:0] data_rdata_o,
  input wire logic [3:0] cmd_rdata_o,
  input wire logic       atten_en_o,
  input wire logic       temp_mon_en_o,
  input wire logic       vchan_short_o,
  input wire logic       wake_sense_en_o,
  input wire logic       lin_passive_o,
  input wire logic       lin_pin_en_o,
  input wire logic       lin_short_flag_o,
  input wire logic       hv_irq_o
);
  logic [15:0] oc_run;
  wire         cfg_wr = cmd_wr_i && cmd_code_i == 4'h9;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Length of the current overcurrent run
  always_ff @(posedge sys_clk_i) begin
    oc_run <= (reset_i || !lin_overcurrent_i) ? 16'h0 : oc_run + {15'h0, oc_run != 16'hFFFF};
  end
  a_data_load: assert property (data_wr_i |=> data_rdata_o == $past(data_wdata_i))
    else $error("bad data load");
  a_cmd_echo: assert property (cmd_wr_i |=> cmd_rdata_o == $past(cmd_code_i))
    else $error("bad command echo");
  a_cfg_bits: assert property (
    cfg_wr |=> {atten_en_o, temp_mon_en_o, vchan_short_o, wake_sense_en_o, lin_passive_o}
      == {$past(data_rdata_o[7:4]), $past(data_rdata_o[2])})
    else $error("bad config bits");
  a_cfg_hold: assert property (
    !cfg_wr |=> $stable(atten_en_o) && $stable(temp_mon_en_o) && $stable(vchan_short_o)
      && $stable(wake_sense_en_o) && $stable(lin_passive_o))
    else $error("config changed unwritten");
  a_lin_reenable: assert property (cfg_wr && data_rdata_o[3] && !lin_overcurrent_i
    && !$past(lin_overcurrent_i) && !$past(lin_overcurrent_i, 2) && !$past(lin_overcurrent_i, 3)
    |=> lin_pin_en_o && !lin_short_flag_o) else $error("lin not re-enabled");
  a_short_irq: assert property ($rose(lin_short_flag_o) |-> hv_irq_o)
    else $error("no irq on short");
  a_passive_keep: assert property (lin_passive_o && lin_pin_en_o |=> lin_pin_en_o)
    else $error("passive pin dropped");
  a_lin_late: assert property ($fell(lin_pin_en_o) |->
    $past(oc_run, 2) >= LIN_SHORT_CYCLES - 1) else $error("lin disabled early");
  a_flag_late: assert property ($rose(lin_short_flag_o) |->
    $past(oc_run, 2) >= LIN_SHORT_CYCLES - 1) else $error("flag set early");
endmodule
bind hvc_config1 hvc_chk #(
  .LIN_SHORT_CYCLES(LIN_SHORT_CYCLES)
) u_chk (
  .sys_clk_i         (sys_clk_i),
  .reset_i           (reset_i),
  .cmd_wr_i          (cmd_wr_i),
  .cmd_code_i        (cmd_code_i),
  .data_wr_i         (data_wr_i),
  .data_wdata_i      (data_wdata_i),
  .lin_overcurrent_i (lin_overcurrent_i),
  .data_rdata_o      (data_rdata_o),
  .cmd_rdata_o       (cmd_rdata_o),
  .atten_en_o        (atten_en_o),
  .temp_mon_en_o     (temp_mon_en_o),
  .vchan_short_o     (vchan_short_o),
  .wake_sense_en_o   (wake_sense_en_o),
  .lin_passive_o     (lin_passive_o),
  .lin_pin_en_o      (lin_pin_en_o),
  .lin_short_flag_o  (lin_short_flag_o),
  .hv_irq_o          (hv_irq_o)
);
`default_nettype wire

// ===== tb_top.sv
/* Self-checking bench for hvc_config1.
   Assumes short thresholds cut to 5 and 8 cycles. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0, rst = 1'b1, cw = 1'b0, dw = 1'b0;
  logic       wp  = 1'b0, lo  = 1'b0, wo = 1'b0, th = 1'b0;
  logic [3:0] cc  = 4'h0, cr;
  logic [7:0] dd  = 8'h00, dr;
  logic       at, tm, vs, ws, lp, le, we, lf, wf, irq;
  int         n_fail = 0, compares = 0, cyc = 0, nirq = 0;
  always #4 clk = ~clk;
  hvc_config1 #(.LIN_SHORT_CYCLES(5), .WAKE_SHORT_CYCLES(8)) dut (.sys_clk_i(clk),
    .reset_i(rst), .cmd_wr_i(cw), .cmd_code_i(cc), .data_wr_i(dw), .data_wdata_i(dd),
    .wake_io_pin_i(wp), .lin_overcurrent_i(lo), .wake_overcurrent_i(wo), .wake_thermal_i(th),
    .data_rdata_o(dr), .cmd_rdata_o(cr), .atten_en_o(at), .temp_mon_en_o(tm),
    .vchan_short_o(vs), .wake_sense_en_o(ws), .lin_passive_o(lp), .lin_pin_en_o(le),
    .wake_pin_en_o(we), .lin_short_flag_o(lf), .wake_short_flag_o(wf), .hv_irq_o(irq));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    nirq <= nirq + int'(irq === 1'b1);
    if (cyc == 4000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmd(input logic [3:0] c);
    @(negedge clk);
    cw = 1'b1;
    cc = c;
    @(negedge clk);
    cw = 1'b0;
  endtask
  task automatic wcfg(input logic [7:0] v);
    @(negedge clk);
    dw = 1'b1;
    dd = v;
    @(negedge clk);
    dw = 1'b0;
    cmd(4'h9);
  endtask
  task automatic t_reset();
    chk("outs", 8'h03, {at, tm, vs, ws, lf, lp, le, we});
    cmd(4'h1);
    chk("readback", 8'h00, dr);
  endtask
  task automatic t_cfg();
    logic [7:0] p [4] = '{8'hA4, 8'h53, 8'hFB, 8'h00};
    foreach (p[i]) begin
      wcfg(p[i]);
      chk("cfg", p[i] & 8'hF4, {at, tm, vs, ws, 1'b0, lp, 2'h0});
      cmd(4'h1);
      chk("readback", p[i], dr);
    end
  endtask
  task automatic t_lin(input logic pas);
    int k;
    wcfg({5'h00, pas, 2'b00});
    repeat (2) begin
      lo = 1'b1;
      repeat (4) @(negedge clk);
      lo = 1'b0;
      @(negedge clk);
    end
    k = nirq;
    lo = 1'b1;
    repeat (6) @(negedge clk);
    chk("early", 8'h01, {6'h00, lf, le});
    repeat (6) @(negedge clk);
    chk("lin", {6'h00, 1'b1, pas}, {6'h00, lf, le});
    chk("irq", 8'h01, 8'(nirq - k));
    lo = 1'b0;
    repeat (4) @(negedge clk);
    wcfg(8'h08);
    chk("cleared", 8'h01, {6'h00, lf, le});
  endtask
  task automatic t_wake();
    wo = 1'b1;
    repeat (14) @(negedge clk);
    wo = 1'b0;
    th = 1'b1;
    chk("wake short", 8'h01, {6'h00, we, wf});
    repeat (4) @(negedge clk);
    th = 1'b0;
    repeat (4) @(negedge clk);
    wcfg(8'h08);
    chk("wake on", 8'h02, {6'h00, we, wf});
    th = 1'b1;
    repeat (4) @(negedge clk);
    wcfg(8'h08);
    chk("thermal hold", 8'h00, {6'h00, we, wf});
    th = 1'b0;
    repeat (4) @(negedge clk);
    wcfg(8'h08);
    chk("thermal on", 8'h02, {6'h00, we, wf});
  endtask
  task automatic t_sense();
    int k;
    wcfg(8'h10);
    k = nirq;
    wp = 1'b1;
    repeat (5) @(negedge clk);
    cmd(4'h3);
    chk("monitor", 8'h80, dr);
    chk("command", 8'h03, {4'h0, cr});
    cmd(4'h5);
    chk("command", 8'h05, {4'h0, cr});
    chk("data kept", 8'h80, dr);
    wp = 1'b0;
    repeat (5) @(negedge clk);
    chk("edges", 8'h02, 8'(nirq - k));
  endtask
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_cfg();
    t_lin(1'b0);
    t_lin(1'b1);
    t_wake();
    t_sense();
    final_report();
  end
endmodule
`default_nettype wire
